// file: src/arll_axis_range_and_limit.sv
/*
 Axis range supervision: linear/modulo position, backlash correction,
 hardware travel limits with faults, and software position limits.
 Assumes encoder_position is sampled on clk; digital input pins are asynchronous.
*/
// Summary of operation
// RL1 - axis type 0 linear, 1 modulo
// RL2 - modulo mode wraps position into range
// RL3 - operator re-references after axis type change
// RL4 - no backlash correction before referencing
// RL5 - reversal applies signed backlash per direction
// RL6 - start direction sets initial compensation
// RL7 - extended telegram: start direction from bit 9
// RL8 - extended telegram: bit 15 enables stop cam
// RL9 - falling limit input gives emergency stop
// RL10 - positioner mode: direction-specific stop faults
// RL11 - ack without leaving limit keeps fault
// RL12 - function code 3 cw, 4 ccw
// RL13 - unmapped limit reads permanently high
// RL14 - limit inputs high at power on
// RL15 - soft limits after referencing stop motor
// RL16 - extended telegram: bit 14 enables soft limits
// RL17 - soft limit values and enable setting
// RL18 - limit event latched until acknowledged
`timescale 1ns/100ps
module arll_axis_range_and_limit
	import arll_pkg::*;
#(
	parameter int NUM_DI = ARLL_NUM_DI
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// settings and control word
	input  wire arll_cfg_t         cfg,
	input  wire logic [15:0]       pos_ctrl_word2,
	input  wire logic              basic_positioner_mode,
	input  wire logic              referenced,
	input  wire logic              fault_ack,
	// motor side
	input  wire logic [NUM_DI-1:0] digital_input_pins,
	input  wire arll_pos_t         encoder_position,
	// results
	output arll_pos_t              position_out,
	output arll_stat_t             stat
);

	generate
		if (NUM_DI < 1 || NUM_DI > ARLL_NUM_DI) begin : g_bad_di
			$error("NUM_DI out of range");
		end
	endgenerate

	arll_state_t            st_r;
	arll_state_t            st_nxt;
	logic [ARLL_NUM_DI-1:0] pins_ext;
	logic                   cw_lvl;
	logic                   ccw_lvl;
	logic                   cw_mapped;
	logic                   cam_en;
	logic                   cw_fall;
	logic                   ccw_fall;
	logic                   start_dir;
	logic                   soft_en;
	arll_pos_t              bl;
	arll_pos_t              offset;
	arll_pos_t              lin_pos;
	logic [ARLL_POS_W-1:0]  rng;
	logic signed [ARLL_POS_W:0] lin_ext;
	logic signed [ARLL_POS_W:0] rng_s;
	logic signed [ARLL_POS_W:0] rem;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		pins_ext = ARLL_DI_IDLE;
		pins_ext[NUM_DI-1:0] = digital_input_pins;
		cw_lvl = 1'b1;
		ccw_lvl = 1'b1;
		cw_mapped = 1'b0;

		// three-stage sync; a change counts once stages two and three agree
		st_nxt.di_s1 = pins_ext;
		st_nxt.di_s2 = st_r.di_s1;
		st_nxt.di_s3 = st_r.di_s2;
		for (int i = 0; i < ARLL_NUM_DI; i++) begin
			if (st_r.di_s2[i] == st_r.di_s3[i]) begin
				st_nxt.di_stable[i] = st_r.di_s3[i];
			end
		end

		// several inputs on one function: any low one counts as reached
		for (int i = 0; i < NUM_DI; i++) begin
			if (cfg.input_function_select[i] == ARLL_FN_CW) begin //RL12
				cw_lvl = cw_lvl & st_r.di_stable[i];
				cw_mapped = 1'b1;
			end
			if (cfg.input_function_select[i] == ARLL_FN_CCW) begin //RL12
				ccw_lvl = ccw_lvl & st_r.di_stable[i];
			end
		end
		st_nxt.cw_level = cw_lvl; //RL13
		st_nxt.ccw_level = ccw_lvl; //RL13

		// ----------------------------------------
		// hardware travel limits
		// ----------------------------------------
		cam_en = cfg.extended_telegram ? pos_ctrl_word2[ARLL_BIT_STOP_CAM] : 1'b1; //RL8
		// reset level is high, so a low input at power on raises a limit event once synchronised
		cw_fall = st_r.cw_level & ~cw_lvl & cam_en; //RL9 RL14
		ccw_fall = st_r.ccw_level & ~ccw_lvl & cam_en; //RL9 RL14
		// ack only clears once the input is back high; set wins over clear
		st_nxt.cw_latched = cw_fall | (st_r.cw_latched & ~(fault_ack & cw_lvl)); //RL18 RL11
		st_nxt.ccw_latched = ccw_fall | (st_r.ccw_latched & ~(fault_ack & ccw_lvl)); //RL18 RL11
		st_nxt.plus_fault = (basic_positioner_mode & cw_fall & st_r.move_pos)
			| (st_r.plus_fault & ~(fault_ack & cw_lvl)); //RL10 RL11
		st_nxt.minus_fault = (basic_positioner_mode & ccw_fall & ~st_r.move_pos)
			| (st_r.minus_fault & ~(fault_ack & ccw_lvl)); //RL10 RL11
		st_nxt.estop = st_nxt.cw_latched | st_nxt.ccw_latched; //RL9

		// ----------------------------------------
		// direction and backlash
		// ----------------------------------------
		st_nxt.prev_raw = encoder_position;
		if (encoder_position > st_r.prev_raw) begin
			st_nxt.move_pos = 1'b1;
		end else if (encoder_position < st_r.prev_raw) begin
			st_nxt.move_pos = 1'b0;
		end
		start_dir = cfg.extended_telegram ? pos_ctrl_word2[ARLL_BIT_START_DIR]
			: cfg.homing_start_direction; //RL7
		st_nxt.ref_prev = referenced;
		if (!referenced) begin
			st_nxt.comp_active = 1'b0; //RL4
			st_nxt.comp_pos = 1'b0;
		end else if (!st_r.ref_prev) begin
			st_nxt.comp_active = 1'b1;
			st_nxt.comp_pos = start_dir; //RL6
		end else if (encoder_position > st_r.prev_raw) begin
			st_nxt.comp_pos = 1'b1; //RL5
		end else if (encoder_position < st_r.prev_raw) begin
			st_nxt.comp_pos = 1'b0; //RL5
		end

		// out-of-range settings are clamped, not rejected
		if (cfg.backlash_amount > ARLL_BACKLASH_MAX) begin
			bl = ARLL_BACKLASH_MAX;
		end else if (cfg.backlash_amount < ARLL_BACKLASH_MIN) begin
			bl = ARLL_BACKLASH_MIN;
		end else begin
			bl = cfg.backlash_amount;
		end
		// one backlash step per reversal: zero going negative, full going positive
		offset = (st_r.comp_active & st_r.comp_pos) ? bl : '0; //RL5 RL4
		lin_pos = encoder_position + offset;

		// ----------------------------------------
		// linear or modulo position
		// ----------------------------------------
		rng = (cfg.modulo_range < ARLL_MODULO_MIN) ? ARLL_MODULO_MIN : cfg.modulo_range;
		lin_ext = {lin_pos[ARLL_POS_W-1], lin_pos};
		rng_s = $signed({1'b0, rng});
		rem = lin_ext % rng_s; //RL2
		if (rem < 0) begin
			rem = rem + rng_s; //RL2
		end
		if (cfg.axis_type_select == ARLL_AXIS_MODULO) begin //RL1
			st_nxt.position = rem[ARLL_POS_W-1:0];
		end else begin
			st_nxt.position = lin_pos; //RL1
		end

		// ----------------------------------------
		// software limits
		// ----------------------------------------
		soft_en = referenced & (cfg.extended_telegram ? pos_ctrl_word2[ARLL_BIT_SOFT_LIMIT]
			: cfg.soft_limit_activate); //RL15 RL16 RL17
		st_nxt.soft_stop = soft_en & ((st_nxt.position >= cfg.positive_soft_limit)
			| (st_nxt.position <= cfg.negative_soft_limit)); //RL15 RL17

		// positions are untrusted until a fresh referencing run
		st_nxt.axis_prev = cfg.axis_type_select;
		if (referenced & ~st_r.ref_prev) begin
			st_nxt.reref = 1'b0;
		end
		if (cfg.axis_type_select != st_r.axis_prev) begin
			st_nxt.reref = 1'b1; //RL3
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= ARLL_STATE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign position_out = st_r.position;
	assign stat.cw_limit_reached = st_r.cw_latched;
	assign stat.ccw_limit_reached = st_r.ccw_latched;
	assign stat.plus_stop_fault = st_r.plus_fault;
	assign stat.minus_stop_fault = st_r.minus_fault;
	assign stat.emergency_stop = st_r.estop;
	assign stat.soft_limit_stop = st_r.soft_stop;
	assign stat.backlash_active = st_r.comp_active;
	assign stat.backlash_dir = st_r.comp_pos;
	assign stat.rereference_needed = st_r.reref;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_cw_fall;
		(st_r.cw_level && cam_en) ##1 !st_r.cw_level;
	endsequence
	sequence s_cw_fall_pos;
		(st_r.cw_level && cam_en && basic_positioner_mode && st_r.move_pos) ##1 !st_r.cw_level;
	endsequence
	sequence s_ccw_fall_neg;
		(st_r.ccw_level && cam_en && basic_positioner_mode && !st_r.move_pos) ##1 !st_r.ccw_level;
	endsequence

	property p_linear_pass;
		(cfg.axis_type_select != ARLL_AXIS_MODULO && !st_r.comp_active)
			|=> position_out == $past(encoder_position);
	endproperty
	a_linear_pass: assert property (p_linear_pass) else $error("linear position not passed"); //RL1

	property p_modulo_wrap;
		cfg.axis_type_select == ARLL_AXIS_MODULO |=> position_out >= 0 &&
			{1'b0, position_out} < {1'b0, $past(rng)};
	endproperty
	a_modulo_wrap: assert property (p_modulo_wrap) else $error("modulo position out of range"); //RL2

	property p_no_comp_unref;
		!referenced |=> !stat.backlash_active ##1 !stat.backlash_active || referenced;
	endproperty
	a_no_comp_unref: assert property (p_no_comp_unref) else $error("backlash active unreferenced"); //RL4

	property p_reverse_pos;
		(st_r.comp_active && referenced && st_r.ref_prev && encoder_position > st_r.prev_raw)
			|=> stat.backlash_dir;
	endproperty
	a_reverse_pos: assert property (p_reverse_pos) else $error("backlash direction not updated"); //RL5

	property p_init_dir;
		$rose(referenced) |=> stat.backlash_active && stat.backlash_dir == $past(start_dir);
	endproperty
	a_init_dir: assert property (p_init_dir) else $error("initial compensation wrong"); //RL6

	property p_ctrl_dir;
		(cfg.extended_telegram && $rose(referenced))
			|=> stat.backlash_dir == $past(pos_ctrl_word2[ARLL_BIT_START_DIR]);
	endproperty
	a_ctrl_dir: assert property (p_ctrl_dir) else $error("start direction bit ignored"); //RL7

	property p_cam_off;
		(cfg.extended_telegram && !pos_ctrl_word2[ARLL_BIT_STOP_CAM] && !stat.emergency_stop)
			|=> !stat.emergency_stop;
	endproperty
	a_cam_off: assert property (p_cam_off) else $error("stop cam not disabled"); //RL8

	property p_cw_estop;
		s_cw_fall |-> stat.emergency_stop && stat.cw_limit_reached;
	endproperty
	a_cw_estop: assert property (p_cw_estop) else $error("no emergency stop on limit"); //RL9

	property p_plus_fault;
		s_cw_fall_pos |-> stat.plus_stop_fault;
	endproperty
	a_plus_fault: assert property (p_plus_fault) else $error("plus stop fault missing"); //RL10

	property p_minus_fault;
		s_ccw_fall_neg |-> stat.minus_stop_fault;
	endproperty
	a_minus_fault: assert property (p_minus_fault) else $error("minus stop fault missing"); //RL10

	property p_ack_in_limit;
		(stat.plus_stop_fault && fault_ack && !cw_lvl) |=> stat.plus_stop_fault && stat.emergency_stop;
	endproperty
	a_ack_in_limit: assert property (p_ack_in_limit) else $error("fault cleared inside limit"); //RL11

	property p_map_cw;
		(cfg.input_function_select[0] == ARLL_FN_CW && !st_r.di_stable[0]) |=> !st_r.cw_level;
	endproperty
	a_map_cw: assert property (p_map_cw) else $error("cw mapping ignored"); //RL12

	property p_unmapped_high;
		!cw_mapped |=> st_r.cw_level;
	endproperty
	a_unmapped_high: assert property (p_unmapped_high) else $error("unmapped limit not high"); //RL13

	property p_soft_cause;
		$rose(stat.soft_limit_stop) |-> $past(referenced) &&
			(position_out >= $past(cfg.positive_soft_limit) || position_out <= $past(cfg.negative_soft_limit));
	endproperty
	a_soft_cause: assert property (p_soft_cause) else $error("soft stop without cause"); //RL15

	property p_soft_bit_off;
		(cfg.extended_telegram && !pos_ctrl_word2[ARLL_BIT_SOFT_LIMIT]) |=> !stat.soft_limit_stop;
	endproperty
	a_soft_bit_off: assert property (p_soft_bit_off) else $error("soft limit bit ignored"); //RL16

	property p_soft_param_off;
		(!cfg.extended_telegram && !cfg.soft_limit_activate) |=> !stat.soft_limit_stop;
	endproperty
	a_soft_param_off: assert property (p_soft_param_off) else $error("soft limit enable ignored"); //RL17

	property p_latch_hold;
		(stat.cw_limit_reached && !fault_ack) [*2] |=> stat.cw_limit_reached;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("limit latch dropped"); //RL18

endmodule

// file: src/arll_pkg.sv
/*
 Constants, carrier structs and state layout of the axis range and limit logic.
 Assumes one control clock and length units as the position scale.
*/
package arll_pkg;
	// ----------------------------------------
	// widths and codes
	// ----------------------------------------
	localparam int         ARLL_POS_W          = 32;
	localparam int         ARLL_NUM_DI         = 4;
	localparam int         ARLL_FN_W           = 4;
	localparam logic [3:0] ARLL_FN_CW          = 4'h3;
	localparam logic [3:0] ARLL_FN_CCW         = 4'h4;
	localparam logic       ARLL_AXIS_MODULO    = 1'b1;
	localparam int         ARLL_BIT_START_DIR  = 9;
	localparam int         ARLL_BIT_SOFT_LIMIT = 14;
	localparam int         ARLL_BIT_STOP_CAM   = 15;
	localparam logic [3:0] ARLL_DI_IDLE        = 4'hF;

	// ----------------------------------------
	// ranges
	// ----------------------------------------
	localparam logic signed [31:0] ARLL_BACKLASH_MAX   = 32'sh00030D40;
	localparam logic signed [31:0] ARLL_BACKLASH_MIN   = 32'shFFFCF2C0;
	localparam logic [31:0]        ARLL_MODULO_MIN     = 32'h00000001;
	localparam logic [31:0]        ARLL_MODULO_DEFAULT = 32'h00057E40;

	typedef logic signed [ARLL_POS_W-1:0] arll_pos_t;

	typedef struct packed {
		logic                                  axis_type_select;
		logic [ARLL_POS_W-1:0]                 modulo_range;
		arll_pos_t                             backlash_amount;
		logic                                  homing_start_direction;
		arll_pos_t                             negative_soft_limit;
		arll_pos_t                             positive_soft_limit;
		logic                                  soft_limit_activate;
		logic                                  extended_telegram;
		logic [ARLL_NUM_DI-1:0][ARLL_FN_W-1:0] input_function_select;
	} arll_cfg_t;

	typedef struct packed {
		logic cw_limit_reached;
		logic ccw_limit_reached;
		logic plus_stop_fault;
		logic minus_stop_fault;
		logic emergency_stop;
		logic soft_limit_stop;
		logic backlash_active;
		logic backlash_dir;
		logic rereference_needed;
	} arll_stat_t;

	typedef struct packed {
		logic [ARLL_NUM_DI-1:0] di_s1;
		logic [ARLL_NUM_DI-1:0] di_s2;
		logic [ARLL_NUM_DI-1:0] di_s3;
		logic [ARLL_NUM_DI-1:0] di_stable;
		logic                   cw_level;
		logic                   ccw_level;
		logic                   cw_latched;
		logic                   ccw_latched;
		logic                   plus_fault;
		logic                   minus_fault;
		logic                   estop;
		arll_pos_t              prev_raw;
		logic                   move_pos;
		logic                   comp_active;
		logic                   comp_pos;
		logic                   ref_prev;
		logic                   axis_prev;
		logic                   reref;
		logic                   soft_stop;
		arll_pos_t              position;
	} arll_state_t;

	localparam arll_state_t ARLL_STATE_RST = '{di_s1: ARLL_DI_IDLE, di_s2: ARLL_DI_IDLE,
		di_s3: ARLL_DI_IDLE, di_stable: ARLL_DI_IDLE, cw_level: 1'b1, ccw_level: 1'b1, default: '0};
endpackage

// file: testbench/arll_far_side.sv
/*
 Far-side model: motor encoder and machine limit switches.
 Assumes the bench drives its commands on the falling clock edge.
*/
`timescale 1ns/100ps
module arll_far_side
	import arll_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// commands from the bench
	input  wire logic       load_en,
	input  wire arll_pos_t  load_val,
	input  wire arll_pos_t  step,
	input  wire logic [3:0] switch_hit,
	// towards the drive
	output arll_pos_t       encoder_position,
	output logic [3:0]      digital_input_pins
);
	// switch contacts open (high) unless the axis sits on them
	assign digital_input_pins = ~switch_hit;

	// encoder moves off the sampling edge so the drive never races it
	always @(negedge clk or negedge reset_n) begin
		if (!reset_n) begin
			encoder_position <= '0;
		end else if (load_en) begin
			encoder_position <= load_val;
		end else begin
			encoder_position <= encoder_position + step;
		end
	end
endmodule

// file: testbench/axis_range_and_limit_logic_tb_top.sv
/*
 Self-checking bench of the axis range and limit logic.
 Assumes the far-side model arll_far_side for encoder and limit switches.
*/
`timescale 1ns/100ps
module axis_range_and_limit_logic_tb_top
	import arll_pkg::*;
;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic             clk = 1'b0;
	logic             reset_n = 1'b0;
	arll_cfg_t        cfg;
	logic [15:0]      word2;
	logic             pmode, refd, ack, load_en;
	arll_pos_t        load_val, step, enc, position_out, v, amt;
	logic [3:0]       hit, pins;
	logic [3:0][3:0]  fsel;
	logic [31:0]      rng;
	arll_stat_t       stat;
	logic             sd;
	int               fails = 0;
	int               total_checks = 0;
	int               k;
	arll_pos_t        sv [9] = '{32'sh3E7, 32'sh3E8, -32'sh3E8, -32'sh3E7, 32'sh1388, 32'sh1388, 32'sh1388,
		32'sh1388, 32'sh0};
	logic [3:0]       sm [9] = '{4'hC, 4'hC, 4'hC, 4'hC, 4'h8, 4'hB, 4'hE, 4'h4, 4'hC};

	always #12.5 clk = ~clk;

	arll_axis_range_and_limit #(.NUM_DI(4)) dut_u (.clk(clk), .reset_n(reset_n), .cfg(cfg),
		.pos_ctrl_word2(word2), .basic_positioner_mode(pmode), .referenced(refd), .fault_ack(ack),
		.digital_input_pins(pins), .encoder_position(enc), .position_out(position_out), .stat(stat));
	arll_far_side far_u (.clk(clk), .reset_n(reset_n), .load_en(load_en), .load_val(load_val), .step(step),
		.switch_hit(hit), .encoder_position(enc), .digital_input_pins(pins));

	// ----------------------------------------
	// tasks and expectations
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic check_pos(input string what, input arll_pos_t exp, input arll_pos_t got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic check_bit(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic lim(input logic cw, input logic ccw, input logic pf, input logic mf, input logic es);
		check_bit("cw_limit_reached", cw, stat.cw_limit_reached);
		check_bit("ccw_limit_reached", ccw, stat.ccw_limit_reached);
		check_bit("plus_stop_fault", pf, stat.plus_stop_fault);
		check_bit("minus_stop_fault", mf, stat.minus_stop_fault);
		check_bit("emergency_stop", es, stat.emergency_stop);
	endtask
	task automatic put(input arll_pos_t p);
		load_val <= p;
		load_en <= 1'b1;
		cyc(1);
		load_en <= 1'b0;
		cyc(3);
	endtask
	task automatic ackp();
		ack <= 1'b1;
		cyc(2);
		ack <= 1'b0;
		cyc(2);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// floor modulo, so negative positions land in 0..range-1
	function automatic arll_pos_t exp_pos(input arll_pos_t p, input logic [31:0] r, input logic modulo);
		longint rr;
		longint m;
		rr = (r == 32'h0) ? 64'sh1 : longint'(r);
		m = longint'(p) % rr;
		if (m < 0) begin
			m = m + rr;
		end
		return modulo ? arll_pos_t'(m) : p;
	endfunction
	function automatic arll_pos_t clampb(input arll_pos_t a);
		return (a > ARLL_BACKLASH_MAX) ? ARLL_BACKLASH_MAX : (a < ARLL_BACKLASH_MIN) ? ARLL_BACKLASH_MIN : a;
	endfunction
	function automatic logic soft_exp(input arll_pos_t p, input logic [3:0] m);
		return m[3] & (m[1] ? m[0] : m[2]) & (p >= 32'sh3E8 || p <= -32'sh3E8);
	endfunction

	// ----------------------------------------
	// tests
	// ----------------------------------------
	// whole run is a few hundred cycles; this margin only catches a hang
	initial begin
		#(25 * 30000);
		fails++;
		finish_test();
	end

	initial begin
		cfg = '0;
		cfg.modulo_range = ARLL_MODULO_DEFAULT;
		{word2, pmode, refd, ack, load_en, load_val, step, hit} = '0;
		k = $urandom(19078);
		cyc(2);
		check_pos("position_out", 32'sh0, position_out);
		check_bit("stat idle", 1'b1, stat === '0);
		cyc(2);
		reset_n <= 1'b1;
		cyc(2);
		for (k = 0; k < 24; k++) begin
			rng = (k == 1) ? 32'h0 : (k == 5) ? 32'h1388 : 32'($urandom_range(1, 5000));
			v = (k == 5) ? 32'sh1388 : int'($urandom_range(0, 32'h001E8480)) - 32'sh000F4240;
			cfg.axis_type_select <= k[0];
			cfg.modulo_range <= rng;
			put(v);
			check_pos("position_out", exp_pos(v, rng, k[0]), position_out);
		end
		cfg.axis_type_select <= 1'b0;
		for (k = 0; k < 4; k++) begin
			amt = (k == 3) ? 32'sh493E0 : int'($urandom_range(0, 2 * ARLL_BACKLASH_MAX)) + ARLL_BACKLASH_MIN;
			v = arll_pos_t'($urandom_range(0, 32'h000186A0));
			sd = k[1] ? ~k[0] : k[0];
			cfg.backlash_amount <= amt;
			cfg.homing_start_direction <= k[0];
			cfg.extended_telegram <= k[1];
			word2 <= {6'h00, ~k[0], 9'h000};
			put(v);
			check_pos("position_out", v, position_out);
			check_bit("rereference_needed", k == 0, stat.rereference_needed);
			refd <= 1'b1;
			cyc(3);
			check_bit("backlash_active", 1'b1, stat.backlash_active);
			check_bit("rereference_needed", 1'b0, stat.rereference_needed);
			check_bit("backlash_dir", sd, stat.backlash_dir);
			check_pos("position_out", v + (sd ? clampb(amt) : 32'sh0), position_out);
			step <= 32'sh1;
			cyc(2);
			step <= 32'sh0;
			cyc(3);
			check_pos("position_out", v + 32'sh2 + clampb(amt), position_out);
			step <= -32'sh1;
			cyc(2);
			step <= 32'sh0;
			cyc(3);
			check_pos("position_out", v, position_out);
			refd <= 1'b0;
			cyc(2);
			check_bit("backlash_active", 1'b0, stat.backlash_active);
		end
		cfg.extended_telegram <= 1'b0;
		cfg.backlash_amount <= '0;
		for (k = 0; k < 4; k++) begin
			fsel = '0;
			fsel[k] = ARLL_FN_CW;
			fsel[(k + 1) % 4] = ARLL_FN_CCW;
			cfg.input_function_select <= fsel;
			pmode <= (k != 3);
			step <= 32'sh1;
			cyc(2);
			hit <= 4'h1 << ((k + 2) % 4);
			cyc(8);
			lim(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
			hit <= 4'h1 << k;
			cyc(8);
			lim(1'b1, 1'b0, k != 3, 1'b0, 1'b1);
			ackp();
			lim(1'b1, 1'b0, k != 3, 1'b0, 1'b1);
			hit <= 4'h0;
			step <= -32'sh1;
			cyc(8);
			lim(1'b1, 1'b0, k != 3, 1'b0, 1'b1);
			ackp();
			lim(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
			hit <= 4'h1 << ((k + 1) % 4);
			cyc(8);
			lim(1'b0, 1'b1, 1'b0, k != 3, 1'b1);
			hit <= 4'h0;
			step <= 32'sh1;
			cyc(8);
			ackp();
			lim(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		end
		// stop cam switched off through the control word, then on again
		cfg.input_function_select <= {4'h0, 4'h0, 4'h0, ARLL_FN_CW};
		cfg.extended_telegram <= 1'b1;
		pmode <= 1'b1;
		cyc(2);
		hit <= 4'h1;
		cyc(8);
		lim(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		hit <= 4'h0;
		cyc(4);
		word2 <= 16'h8000;
		cyc(2);
		hit <= 4'h1;
		cyc(8);
		lim(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
		hit <= 4'h0;
		step <= 32'sh0;
		cyc(8);
		ackp();
		cfg.negative_soft_limit <= -32'sh3E8;
		cfg.positive_soft_limit <= 32'sh3E8;
		for (k = 0; k < 9; k++) begin
			v = (k == 8) ? int'($urandom_range(0, 32'h1770)) - 32'sh0BB8 : sv[k];
			refd <= sm[k][3];
			cfg.soft_limit_activate <= sm[k][2];
			cfg.extended_telegram <= sm[k][1];
			word2 <= {1'b0, sm[k][0], 14'h0000};
			put(v);
			check_bit("soft_limit_stop", soft_exp(v, sm[k]), stat.soft_limit_stop);
		end
		finish_test();
	end
endmodule
